// >>> hw/adcpt_pkg.sv
package adcpt_pkg;
    // ************************************************************
    // Widths
    // ************************************************************
    localparam int RES_W   = 10;  // Result width
    localparam int SAMP_W  = 5;   // Sampling extension field
    localparam int PRESCALE_SELECT_W = 3;   // Prescale select field
    localparam int CH_W    = 5;   // Channel select field
    localparam int REF_W   = 3;   // Reference select field
    localparam int CNT_W   = 9;   // Prescaler counter, divides up to 256
    localparam int STEP_W  = 6;   // Converter clock step counter
    localparam int BIT_W   = 4;   // Approximation bit index

    // ************************************************************
    // Conversion timing, in converter clock cycles
    // ************************************************************
    localparam int NORMAL_CYCLES = 13;  // Length with no extension
    localparam int HOLD_DELAY    = 2;   // Start to sample-and-hold

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_SAMPLE = 8'h04;
    localparam logic [7:0] OFS_SELECT = 8'h08;
    localparam logic [7:0] OFS_CMD    = 8'h0C;
    localparam logic [7:0] OFS_FLAGS  = 8'h10;
    localparam logic [7:0] OFS_RESULT = 8'h14;
    localparam logic [7:0] OFS_ACTIVE = 8'h18;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_PRESCALE_SELECT_LSB = 8;
    localparam int SEL_REF_LSB    = 8;
    localparam int CMD_START_BIT  = 0;
    localparam int CMD_EVEN_BIT   = 1;
    localparam int FLAG_RDY_BIT   = 0;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [PRESCALE_SELECT_W-1:0] RST_PRESCALE_SELECT = 3'h0;
    localparam logic [SAMP_W-1:0]  RST_SAMP  = 5'h00;
    localparam logic [CH_W-1:0]    RST_CH    = 5'h00;
    localparam logic [REF_W-1:0]   RST_REF   = 3'h0;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic [CH_W-1:0]  channel;    // Input channel
        logic [REF_W-1:0] reference;  // Voltage reference
    } adcpt_sel_s;

    typedef struct packed {
        logic [7:0] addr;   // Low address byte of the data phase
        logic       write;  // Write transfer
        logic       valid;  // Data phase pending
    } adcpt_req_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_CONV
    } adcpt_state_e;
endpackage

// >>> hw/adcpt_ctrl.sv
// Functional notes
// - Prescaler derives converter clock, software selects division
// - Prescaler runs while enabled, zero otherwise
// - Start bit write starts at next tick
// - Normal conversion lasts 13 converter cycles
// - Sample-length field extends the sampling phase
// - Sample-and-hold two cycles after start
// - Completion stores result, sets ready flag
// - Result read or write-one clears flag
// - Any start trigger resets the prescaler
// - Event start holds three cycles after edge
// - Restart after completion on next tick
// - Holding register feeds active selection when enabled and idle
// - Selection frozen while conversion runs
// - Selection updates again in final cycle
// - Codes run from zero to all ones
// - Start bit reads one while converting
// - Event edge sets start bit, done clears
// - Ten-bit result right-justified in register
module adcpt_ctrl
    import adcpt_pkg::*;
#(
    parameter int RES_BITS  = adcpt_pkg::RES_W,
    parameter int SAMP_BITS = adcpt_pkg::SAMP_W
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic [31:0]             hrdata,
    input  wire logic               event_in,
    input  wire logic               cmp_in,
    output logic                    sample_hold,
    output logic [RES_BITS-1:0]     dac_code,
    output adcpt_pkg::adcpt_sel_s   active_sel,
    output logic                    conv_busy
);
    import adcpt_pkg::*;

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // The step counter and bit index are sized for these limits
    if (RES_BITS < 2 || RES_BITS > 16 || RES_BITS + HOLD_DELAY + 1 != NORMAL_CYCLES
        || SAMP_BITS < 1 || SAMP_BITS > STEP_W - 1) begin : g_bad_param
        $error("adcpt_ctrl: unsupported parameter values");
    end

    // ************************************************************
    // Declarations
    // ************************************************************
    adcpt_req_s           req;          // Captured address phase
    adcpt_state_e         state;        // Sequencer state
    adcpt_sel_s           hold_sel;     // Holding register for selection
    logic                 enable;       // Converter enable
    logic [PRESCALE_SELECT_W-1:0]   prescale_select;        // prescale_select
    logic [SAMP_BITS-1:0] samp;         // sample_length_field
    logic                 event_en;     // event_start_input_enable
    logic                 start_conv;   // start_conversion_bit
    logic                 ready_flag;   // result_ready_flag
    logic [RES_BITS-1:0]  result;       // result_register
    logic [CNT_W-1:0]     prescale_select_cnt;    // Prescaler counter
    logic [STEP_W-1:0]    step;         // Ticks since conversion start
    logic [BIT_W-1:0]     bit_idx;      // Bit under trial
    logic                 ev_meta;      // Event synchroniser stage 1
    logic                 ev_sync;      // Event synchroniser stage 2
    logic                 ev_last;      // Previous synced event level
    logic                 cmp_meta;     // Comparator synchroniser stage 1
    logic                 cmp_sync;     // Comparator synchroniser stage 2
    logic                 accept;       // Address phase taken
    logic                 wr_ok;        // Write data phase
    logic                 rd_ok;        // Read data phase
    logic                 sw_start;     // Software start write
    logic                 ev_edge;      // Rising event edge
    logic                 trigger;      // Start accepted
    logic [CNT_W-1:0]     div_last;     // Terminal prescaler count
    logic                 tick;         // Converter clock enable
    logic [STEP_W-1:0]    next_step;    // Step after this tick
    logic [STEP_W-1:0]    hold_step;    // Step of sample-and-hold
    logic [STEP_W-1:0]    last_step;    // Step of completion
    logic                 final_tick;   // Completion tick
    logic                 locked;       // Selection frozen
    logic                 clr_flag;     // Software clears ready flag

    // ************************************************************
    // Combinational decode
    // ************************************************************
    assign accept    = hsel && htrans[1] && hready;
    assign wr_ok     = req.valid && req.write;
    assign rd_ok     = req.valid && !req.write;
    assign sw_start  = wr_ok && req.addr == OFS_CMD && hwdata[CMD_START_BIT];
    assign ev_edge   = event_en && ev_sync && !ev_last;
    // Starts while busy are dropped, not queued
    // busy blocks start
    assign trigger   = enable && !start_conv && (sw_start || ev_edge);
    assign div_last  = (9'h002 << prescale_select) - 9'h001;
    assign tick      = enable && prescale_select_cnt == div_last;
    assign next_step = step + 6'h01;
    assign hold_step = STEP_W'(HOLD_DELAY) + STEP_W'(samp);
    assign last_step = STEP_W'(NORMAL_CYCLES - 1) + STEP_W'(samp);
    assign final_tick = state == ST_CONV && tick && next_step == last_step;
    assign locked    = state == ST_CONV && step < last_step - 6'h01;
    assign clr_flag  = (rd_ok && req.addr == OFS_RESULT)
                    || (wr_ok && req.addr == OFS_FLAGS && hwdata[FLAG_RDY_BIT]);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Both pins are asynchronous; only stage 2 is looked at
    always_ff @(posedge clk) begin
        if (rst) begin
            ev_meta  <= 1'b0;
            ev_sync  <= 1'b0;
            ev_last  <= 1'b0;
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else begin
            ev_meta  <= event_in;
            ev_sync  <= ev_meta;
            ev_last  <= ev_sync;
            cmp_meta <= cmp_in;
            cmp_sync <= cmp_meta;
        end
    end

    // ************************************************************
    // Bus slave
    // ************************************************************
    // One wait state per transfer so read data comes from a flop
    always_ff @(posedge clk) begin
        if (rst) begin
            req       <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            req.valid <= accept;
            req.write <= hwrite;
            req.addr  <= haddr[7:0];
            hreadyout <= !accept;
            hresp     <= 1'b0;  // Always OKAY
        end
    end

    // Read mux, loaded in the data phase; unmapped reads give zero
    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_ok) begin
            hrdata <= 32'h0000_0000;
            case (req.addr)
                OFS_CTRL: begin
                    hrdata[CTRL_EN_BIT] <= enable;
                    hrdata[CTRL_PRESCALE_SELECT_LSB +: PRESCALE_SELECT_W] <= prescale_select;
                end
                OFS_SAMPLE: begin
                    hrdata[SAMP_BITS-1:0] <= samp;
                end
                OFS_SELECT: begin
                    hrdata[CH_W-1:0] <= hold_sel.channel;
                    hrdata[SEL_REF_LSB +: REF_W] <= hold_sel.reference;
                end
                OFS_CMD: begin
                    hrdata[CMD_START_BIT] <= start_conv;
                    hrdata[CMD_EVEN_BIT] <= event_en;
                end
                OFS_FLAGS: begin
                    hrdata[FLAG_RDY_BIT] <= ready_flag;
                end
                OFS_RESULT: begin
                    hrdata[RES_BITS-1:0] <= result;
                end
                OFS_ACTIVE: begin
                    hrdata[CH_W-1:0] <= active_sel.channel;
                    hrdata[SEL_REF_LSB +: REF_W] <= active_sel.reference;
                end
                default: begin
                    hrdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            enable   <= 1'b0;
            prescale_select    <= RST_PRESCALE_SELECT;
            samp     <= SAMP_BITS'(RST_SAMP);
            event_en <= 1'b0;
            hold_sel <= '{channel: RST_CH, reference: RST_REF};
        end else if (wr_ok) begin
            case (req.addr)
                OFS_CTRL: begin
                    enable <= hwdata[CTRL_EN_BIT];
                    prescale_select  <= hwdata[CTRL_PRESCALE_SELECT_LSB +: PRESCALE_SELECT_W];
                end
                OFS_SAMPLE: begin
                    samp <= hwdata[SAMP_BITS-1:0];
                end
                OFS_SELECT: begin
                    hold_sel.channel   <= hwdata[CH_W-1:0];
                    hold_sel.reference <= hwdata[SEL_REF_LSB +: REF_W];
                end
                OFS_CMD: begin
                    event_en <= hwdata[CMD_EVEN_BIT];
                end
                default: begin
                    enable <= enable;
                end
            endcase
        end
    end

    // ************************************************************
    // Prescaler
    // ************************************************************
    // held at zero while disabled
    always_ff @(posedge clk) begin
        if (rst || !enable || trigger || tick) begin
            prescale_select_cnt <= '0;
        end else begin
            prescale_select_cnt <= prescale_select_cnt + 9'h001;
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Disabling aborts any conversion in flight
    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            state <= ST_IDLE;
            step  <= '0;
        end else begin
            case (state)
                // accepts a new start after completion
                ST_IDLE: begin
                    if (trigger) begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (tick) begin
                        state <= ST_CONV;
                        step  <= '0;
                    end
                end
                // ends at step twelve plus extension
                ST_CONV: begin
                    if (tick) begin
                        step <= next_step;
                        if (final_tick) begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Busy bit: set by any accepted start, cleared as completion sets the flag
    // event edge sets, completion clears
    always_ff @(posedge clk) begin
        if (rst) begin
            start_conv <= 1'b0;
        end else begin
            start_conv <= trigger || (start_conv && enable && !final_tick);
        end
    end

    // ************************************************************
    // Successive approximation
    // ************************************************************
    // The comparator is sampled two clocks late; the fastest divider
    // setting leaves it no time to settle
    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            dac_code    <= '0;
            bit_idx     <= '0;
            sample_hold <= 1'b0;
        end else begin
            sample_hold <= 1'b0;
            if (state == ST_CONV && tick) begin
                if (next_step == hold_step) begin
                    sample_hold <= 1'b1;
                    dac_code    <= RES_BITS'(1) << (RES_BITS - 1);
                    bit_idx     <= BIT_W'(RES_BITS - 1);
                end else if (next_step > hold_step) begin
                    dac_code[bit_idx] <= cmp_sync;
                    if (bit_idx != '0) begin
                        dac_code[bit_idx - 4'h1] <= 1'b1;
                        bit_idx <= bit_idx - 4'h1;
                    end
                end
            end
        end
    end

    // ************************************************************
    // Result and ready flag
    // ************************************************************
    // code spans zero to all ones
    always_ff @(posedge clk) begin
        if (rst) begin
            result <= '0;
        end else if (final_tick) begin
            result <= {dac_code[RES_BITS-1:1], cmp_sync};
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            ready_flag <= 1'b0;
        end else begin
            ready_flag <= final_tick || (ready_flag && !clr_flag);
        end
    end

    // ************************************************************
    // Channel and reference selection
    // ************************************************************
    // frozen while locked
    always_ff @(posedge clk) begin
        if (rst) begin
            active_sel <= '{channel: RST_CH, reference: RST_REF};
        end else if (enable && !locked) begin
            active_sel <= hold_sel;
        end
    end

    assign conv_busy = start_conv;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_final;
        state == ST_CONV && tick && next_step == last_step;
    endsequence

    sequence s_start_tick;
        state == ST_WAIT && tick;
    endsequence

    a_prescale_select_held: assert property (!enable |=> prescale_select_cnt == '0)
        else $error("prescaler not held while disabled");
    a_tick_ratio: assert property (tick |-> prescale_select_cnt == (9'h002 << prescale_select) - 9'h001)
        else $error("converter tick at wrong count");
    a_trig_reset: assert property (trigger |=> prescale_select_cnt == '0 && state == ST_WAIT)
        else $error("trigger did not reset prescaler");
    a_start_tick: assert property (s_start_tick ##0 enable |=> state == ST_CONV && step == '0)
        else $error("conversion did not begin on tick");
    a_hold_time: assert property (sample_hold |-> step == STEP_W'(HOLD_DELAY) + STEP_W'(samp))
        else $error("sample-and-hold at wrong step");
    a_conv_length: assert property (s_final |-> step == STEP_W'(NORMAL_CYCLES - 2) + STEP_W'(samp))
        else $error("conversion length wrong");
    a_done_flag: assert property (s_final |=> ready_flag && !start_conv && state == ST_IDLE)
        else $error("completion did not set flag and clear start");
    a_flag_clear: assert property (clr_flag && !final_tick |=> !ready_flag)
        else $error("ready flag not cleared");
    a_sel_frozen: assert property (locked && $past(locked) |-> $stable(active_sel))
        else $error("selection changed while locked");
    a_sel_follow: assert property (enable && !locked |=> active_sel == $past(hold_sel))
        else $error("selection not updated while unlocked");
    a_no_restart: assert property (state == ST_CONV && enable && !final_tick |=> state == ST_CONV)
        else $error("conversion aborted by start");
endmodule

// >>> verif/adcpt_ctrl_tb.sv
module adcpt_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import adcpt_pkg::*;
    // ************************************************************
    // Bench signals
    // ************************************************************
    logic        clk = 1'b0;       // 250 MHz clock
    logic        rst = 1'b1;       // Held for the first 4 edges
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;     // Whole words only
    logic [31:0] hwdata = 32'h0;
    logic        event_in = 1'b0;  // Event trigger pin
    logic        cmp_in = 1'b0;    // Held steady so the code is known
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        sample_hold;
    logic [9:0]  dac_code;
    adcpt_sel_s  active_sel;
    logic        conv_busy;
    int          num_errors = 0;
    int          tests_run = 0;
    int          cyc = 0;          // Rising edges so far
    int          sh_cyc;           // Edge of the last hold pulse
    int          sh_cnt = 0;       // Hold pulses so far
    int          rise_cyc;         // Edge where busy rose
    int          fall_cyc;         // Edge where busy fell
    logic [9:0]  sh_dac;           // Trial code at the hold pulse
    logic [7:0]  sel_fall;         // Active selection as busy fell
    logic        busy_q = 1'b0;

    always #2 clk = ~clk;

    always @(posedge clk) cyc <= cyc + 1;

    // Watch outputs at the falling edge, where they have settled
    always @(negedge clk) begin
        if (sample_hold === 1'b1) begin
            sh_cyc = cyc;
            sh_cnt++;
            sh_dac = dac_code;
        end
        if (conv_busy === 1'b1 && busy_q !== 1'b1) rise_cyc = cyc;
        if (conv_busy !== 1'b1 && busy_q === 1'b1) begin
            fall_cyc = cyc;
            sel_fall = active_sel;
        end
        busy_q = conv_busy;
    end

    adcpt_ctrl dut (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .event_in(event_in),
        .cmp_in(cmp_in), .sample_hold(sample_hold), .dac_code(dac_code),
        .active_sel(active_sel), .conv_busy(conv_busy)
    );

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic final_report();
        if (num_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One single AHB-Lite transfer; a stuck bus ends the run
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
        rd = hrdata;
        if (n >= 50) begin
            num_errors++;
            final_report();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string what);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(what, e, r & m);
        chk("hresp", 32'h0, 32'(hresp));
    endtask

    // Bounded wait until the converter goes idle
    task automatic wait_idle();
        int n;
        for (n = 0; n < 5000 && conv_busy !== 1'b0; n++) @(negedge clk);
        if (n >= 5000) begin
            num_errors++;
            final_report();
        end
        @(posedge clk);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        logic [7:0] ofs [7] = '{OFS_CTRL, OFS_SAMPLE, OFS_SELECT, OFS_CMD, OFS_FLAGS,
                                OFS_RESULT, 8'h40};
        @(negedge clk);
        chk("rst_busy", 32'h0, 32'(conv_busy));
        chk("rst_sel", 32'h0, 32'(active_sel));
        foreach (ofs[i]) rchk(ofs[i], 32'hFFFFFFFF, 32'h0, "rst_reg");
        wr(8'h40, 32'hFFFFFFFF);
        rchk(8'h40, 32'hFFFFFFFF, 32'h0, "unmapped");
    endtask

    // Software start; the second start in mid-run must not restart it
    task automatic t_conv(input int p, input int s, input logic c, input logic w1c);
        int d;
        int t;
        int n0;
        d = 2 << p;
        n0 = sh_cnt;
        cmp_in <= c;
        wr(OFS_CTRL, 32'((p << CTRL_PRESCALE_SELECT_LSB) | 1));
        wr(OFS_SAMPLE, 32'(s));
        wr(OFS_CMD, 32'h1);
        @(negedge clk);
        t = cyc - 1;
        rchk(OFS_CMD, 32'h1, 32'h1, "start_busy");
        wr(OFS_CMD, 32'h1);
        wait_idle();
        chk("sh_delay", 32'(d * (3 + s)), 32'(sh_cyc - t));
        chk("sh_count", 32'h1, 32'(sh_cnt - n0));
        chk("sh_code", 32'h200, 32'(sh_dac));
        chk("conv_len", 32'(d * (13 + s)), 32'(fall_cyc - rise_cyc));
        rchk(OFS_CMD, 32'h1, 32'h0, "start_done");
        rchk(OFS_FLAGS, 32'h1, 32'h1, "flag_set");
        if (w1c) begin
            wr(OFS_FLAGS, 32'h1);
            rchk(OFS_FLAGS, 32'h1, 32'h0, "flag_w1c");
        end
        rchk(OFS_RESULT, 32'hFFFFFFFF, c ? 32'h3FF : 32'h0, "result");
        rchk(OFS_FLAGS, 32'h1, 32'h0, "flag_read");
    endtask

    // Selection follows while idle, freezes in the run, catches up at the end
    task automatic t_sel();
        int t;
        wr(OFS_CTRL, 32'h1);
        wr(OFS_SAMPLE, 32'h0);
        wr(OFS_SELECT, 32'h050A);
        repeat (2) @(negedge clk);
        chk("sel_idle", 32'h55, 32'(active_sel));
        wr(OFS_CMD, 32'h1);
        @(negedge clk);
        t = cyc - 1;
        wr(OFS_SELECT, 32'h0213);
        repeat (t + 23 - cyc) @(negedge clk);
        chk("sel_frozen", 32'h55, 32'(active_sel));
        wait_idle();
        chk("sel_final", 32'h9A, 32'(sel_fall));
        rchk(OFS_ACTIVE, 32'h7FF, 32'h213, "sel_active");
        rchk(OFS_RESULT, 32'h0, 32'h0, "sel_clear");
    endtask

    // Event edge starts a conversion like a software write
    task automatic t_event();
        int n0;
        n0 = sh_cnt;
        wr(OFS_CMD, 32'h2);
        event_in <= 1'b1;
        repeat (4) @(posedge clk);
        event_in <= 1'b0;
        rchk(OFS_CMD, 32'h1, 32'h1, "event_start");
        wait_idle();
        chk("event_len", 32'd26, 32'(fall_cyc - rise_cyc));
        chk("event_sh", 32'd20, 32'(fall_cyc - sh_cyc));
        chk("event_count", 32'h1, 32'(sh_cnt - n0));
        wr(OFS_CMD, 32'h0);
        rchk(OFS_RESULT, 32'h0, 32'h0, "event_clear");
    endtask

    // Clearing enable aborts the run and blocks new starts
    task automatic t_abort();
        int n0;
        n0 = sh_cnt;
        wr(OFS_CTRL, 32'h201);
        wr(OFS_CMD, 32'h1);
        wr(OFS_CTRL, 32'h200);
        repeat (40) @(negedge clk);
        chk("abort_busy", 32'h0, 32'(conv_busy));
        chk("abort_sh", 32'h0, 32'(sh_cnt - n0));
        wr(OFS_CMD, 32'h1);
        repeat (4) @(negedge clk);
        chk("off_start", 32'h0, 32'(conv_busy));
        rchk(OFS_FLAGS, 32'h1, 32'h0, "abort_flag");
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_conv(0, 0, 1'b1, 1'b0);
        t_conv(1, 3, 1'b0, 1'b1);
        t_conv(2, 31, 1'b1, 1'b1);
        t_sel();
        t_event();
        t_abort();
        final_report();
    end
endmodule
